// ### logic/via_dev.sv
// How it works
// - Pin edge: rising/falling enable pair selects
// - Edge enables reset zero, upper bits zero
// - Capture edge code: fall, rise, both
// - Prescaler register resets zero, byte writes only
// - Change capture edges only with timer stopped
// - Software writes ones to third priority upper
// - Watchdog mode one needs its priority one
// - Status word resets to 02H
// - Status word byte, bit, push/pop, returns
// - Non-maskable taken regardless, outranks maskable, yields to trap
// - Non-maskable: push, clear both flags, vector
// - Nested non-maskable waits return plus one
// - Many non-maskable during service: one kept
// - Maskable: request, unmasked, enabled, priority check
// - Maskable latency 7-32 or 8-33 clocks
// - Higher programmed level, then default order
// - Pending maskable stays latched until taken
// - Maskable: push, clear enable, copy priority
// - Trap always taken, vector 003EH
// - Trap handlers end with break return
// - Default priority 0 highest to 18
// - Request flag set by source, cleared by ack
//
// Added by the designer: the strobed register port.
`include "via_defs.svh"
`default_nettype none
module via_dev #(
  parameter int NSRC = `VIA_NSRC
) (
  input  wire logic            i_clk_sys,
  input  wire logic            i_arst_n,
  input  wire logic [NSRC-1:0] i_src_pulse,
  input  wire logic [2:0]      i_ext_pin,
  input  wire logic [2:0]      i_capture_pin,
  input  wire logic            i_wdt_overflow,
  input  wire logic            i_wdt_nmi_mode,
  output logic                 o_nmi_busy,
  via_link_if.dev              lnk
);
  logic [5:0]      pin_s1_r;
  logic [5:0]      pin_s2_r;
  logic [5:0]      pin_d_r;
  logic [5:0]      rise;
  logic [5:0]      fall;
  logic [2:0]      rise_en_r;
  logic [2:0]      fall_en_r;
  logic [7:0]      prm_r;
  logic [7:0]      psw_r;
  logic [NSRC-1:0] req_r;
  logic [NSRC-1:0] msk_r;
  logic [NSRC-1:0] pri_r;
  logic [NSRC-1:0] fire;
  logic [NSRC-1:0] req_clr;
  logic [NSRC-1:0] elig;
  logic [NSRC-1:0] hi_set;
  logic [NSRC-1:0] lo_set;
  logic [23:0]     req_w;
  logic [23:0]     msk_w;
  logic [23:0]     pri_w;
  logic [4:0]      hi_idx;
  logic [4:0]      lo_idx;
  logic            sel_pr_r;
  logic            nmi_pend_r;
  logic            nmi_busy_r;
  logic            nmi_take;
  logic            wr;
  logic            full;
  via_pkg::via_ack_type  st_r;
  via_pkg::via_kind_type kind_r;

  // Bit-masked write merge, shared by all byte registers except PRM
  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] wd,
                                       input logic [7:0] m);
    merge = (old_v & ~m) | (wd & m);
  endfunction : merge

  // Lowest set index wins, so default order follows numbering
  function automatic logic [4:0] first_set(input logic [NSRC-1:0] v);
    first_set = 5'h1F;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 5'(i);
      end
    end
  endfunction : first_set

  // Pins come from outside: two flops, then a history flop
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_s1_r <= 6'h00;
      pin_s2_r <= 6'h00;
      pin_d_r  <= 6'h00;
    end else begin
      pin_s1_r <= {i_capture_pin, i_ext_pin};
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
    end
  end
  assign rise = pin_s2_r & ~pin_d_r;
  assign fall = ~pin_s2_r & pin_d_r;

  // Source events; pins and captures replace their pulse inputs
  always_comb begin
    fire = i_src_pulse;
    fire[`VIA_SRC_WDT] = i_src_pulse[`VIA_SRC_WDT] | (i_wdt_overflow & ~i_wdt_nmi_mode);
    for (int n = 0; n < 3; n++) begin
      fire[`VIA_SRC_PIN0 + n] = (rise_en_r[n] & rise[n]) | (fall_en_r[n] & fall[n]);
      case (prm_r[2 + 2 * n +: 2])
        2'h0:    fire[`VIA_SRC_CAP0 + n] = fall[3 + n];
        2'h1:    fire[`VIA_SRC_CAP0 + n] = rise[3 + n];
        2'h3:    fire[`VIA_SRC_CAP0 + n] = rise[3 + n] | fall[3 + n];
        default: fire[`VIA_SRC_CAP0 + n] = 1'b0; // Prohibited code detects nothing
      endcase
    end
  end

  assign wr   = lnk.reg_we;
  assign full = (lnk.reg_bitmask == 8'hFF);
  assign req_w = {merge(8'(req_r[NSRC-1:16]), lnk.reg_wdata, lnk.reg_bitmask),
                  merge(req_r[15:8], lnk.reg_wdata, lnk.reg_bitmask),
                  merge(req_r[7:0], lnk.reg_wdata, lnk.reg_bitmask)};
  assign msk_w = {merge(8'(msk_r[NSRC-1:16]), lnk.reg_wdata, lnk.reg_bitmask),
                  merge(msk_r[15:8], lnk.reg_wdata, lnk.reg_bitmask),
                  merge(msk_r[7:0], lnk.reg_wdata, lnk.reg_bitmask)};
  assign pri_w = {merge(8'(pri_r[NSRC-1:16]), lnk.reg_wdata, lnk.reg_bitmask),
                  merge(pri_r[15:8], lnk.reg_wdata, lnk.reg_bitmask),
                  merge(pri_r[7:0], lnk.reg_wdata, lnk.reg_bitmask)};

  // Edge enables and capture modes
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rise_en_r <= 3'(`VIA_RST_EDGE);
      fall_en_r <= 3'(`VIA_RST_EDGE);
      prm_r     <= `VIA_RST_PRM;
    end else if (wr) begin
      if (lnk.reg_addr == `VIA_ADDR_RISE) begin
        rise_en_r <= 3'(merge(8'(rise_en_r), lnk.reg_wdata, lnk.reg_bitmask));
      end
      if (lnk.reg_addr == `VIA_ADDR_FALL) begin
        fall_en_r <= 3'(merge(8'(fall_en_r), lnk.reg_wdata, lnk.reg_bitmask));
      end
      if (lnk.reg_addr == `VIA_ADDR_PRM && full) begin
        prm_r <= lnk.reg_wdata;
      end
    end
  end

  // Mask and priority banks
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      msk_r <= `VIA_RST_MSKPRI;
      pri_r <= `VIA_RST_MSKPRI;
    end else if (wr) begin
      case (lnk.reg_addr)
        `VIA_ADDR_MSK0: msk_r[7:0]       <= msk_w[7:0];
        `VIA_ADDR_MSK1: msk_r[15:8]      <= msk_w[15:8];
        `VIA_ADDR_MSK2: msk_r[NSRC-1:16] <= msk_w[NSRC-1:16];
        `VIA_ADDR_PRI0: pri_r[7:0]       <= pri_w[7:0];
        `VIA_ADDR_PRI1: pri_r[15:8]      <= pri_w[15:8];
        `VIA_ADDR_PRI2: pri_r[NSRC-1:16] <= pri_w[NSRC-1:16];
        default: ;
      endcase
    end
  end

  // Request flags: set beats write and acknowledge clear
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      req_r <= '0;
    end else begin
      req_r <= (req_r & ~req_clr) | fire;
      if (wr && lnk.reg_addr == `VIA_ADDR_REQ0) begin
        req_r[7:0] <= (req_w[7:0] & ~req_clr[7:0]) | fire[7:0];
      end
      if (wr && lnk.reg_addr == `VIA_ADDR_REQ1) begin
        req_r[15:8] <= (req_w[15:8] & ~req_clr[15:8]) | fire[15:8];
      end
      if (wr && lnk.reg_addr == `VIA_ADDR_REQ2) begin
        req_r[NSRC-1:16] <= (req_w[NSRC-1:16] & ~req_clr[NSRC-1:16]) | fire[NSRC-1:16];
      end
    end
  end

  // Maskable eligibility and two-level selection
  assign elig   = req_r & ~msk_r;
  assign hi_set = elig & ~pri_r & {NSRC{psw_r[`VIA_IEN_BIT]}};
  assign lo_set = elig & pri_r & {NSRC{psw_r[`VIA_IEN_BIT] & psw_r[`VIA_INSV_BIT]}};
  assign hi_idx = first_set(hi_set);
  assign lo_idx = first_set(lo_set);
  // Hold instructions and returns delay the decision one boundary
  assign nmi_take = nmi_pend_r & ~nmi_busy_r & ~lnk.hold;

  // Acknowledge sequencing at instruction boundaries
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r      <= via_pkg::VIA_A_IDLE;
      kind_r    <= via_pkg::VIA_KIND_MASK;
      sel_pr_r  <= 1'b0;
      req_clr   <= '0;
      lnk.ack     <= 1'b0;
      lnk.ack_vec <= 16'h0000;
    end else begin
      lnk.ack <= 1'b0;
      req_clr <= '0;
      case (st_r)
        via_pkg::VIA_A_IDLE: begin
          if (lnk.bnd) begin
            if (lnk.trap) begin
              kind_r      <= via_pkg::VIA_KIND_SOFT;
              lnk.ack_vec <= `VIA_VEC_TRAP;
              lnk.ack     <= 1'b1;
              st_r        <= via_pkg::VIA_A_WAIT;
            end else if (nmi_take) begin
              kind_r      <= via_pkg::VIA_KIND_NMI;
              lnk.ack_vec <= `VIA_VEC_NMI;
              lnk.ack     <= 1'b1;
              st_r        <= via_pkg::VIA_A_WAIT;
            end else if (!lnk.hold && (|hi_set || |lo_set)) begin
              kind_r      <= via_pkg::VIA_KIND_MASK;
              sel_pr_r    <= ~(|hi_set);
              lnk.ack_vec <= `VIA_VEC_BASE + {10'h000, ((|hi_set) ? hi_idx : lo_idx), 1'b0};
              req_clr[(|hi_set) ? hi_idx : lo_idx] <= 1'b1;
              lnk.ack     <= |hi_set;
              // Low level answers one clock later than high
              st_r        <= (|hi_set) ? via_pkg::VIA_A_WAIT : via_pkg::VIA_A_DLY;
            end
          end
        end
        via_pkg::VIA_A_DLY: begin
          lnk.ack <= 1'b1;
          st_r    <= via_pkg::VIA_A_WAIT;
        end
        via_pkg::VIA_A_WAIT: begin
          if (lnk.ack_done) begin
            st_r <= via_pkg::VIA_A_IDLE;
          end
        end
        default: begin
          st_r <= via_pkg::VIA_A_IDLE;
        end
      endcase
    end
  end
  assign lnk.ack_kind = kind_r;

  // Non-maskable pending and in-service; repeats collapse to one
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      nmi_pend_r <= 1'b0;
      nmi_busy_r <= 1'b0;
    end else begin
      if (st_r == via_pkg::VIA_A_IDLE && lnk.bnd && !lnk.trap && nmi_take) begin
        nmi_pend_r <= 1'b0;
        nmi_busy_r <= 1'b1;
      end else if (lnk.interrupt_return_instr) begin
        nmi_busy_r <= 1'b0;
      end
      if (i_wdt_overflow && i_wdt_nmi_mode) begin
        nmi_pend_r <= 1'b1;
      end
    end
  end
  assign o_nmi_busy = nmi_busy_r;

  // Status word; stacking end beats a software write
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      psw_r <= `VIA_RST_PSW;
    end else if (st_r == via_pkg::VIA_A_WAIT && lnk.ack_done) begin
      psw_r[`VIA_IEN_BIT] <= 1'b0;
      if (kind_r == via_pkg::VIA_KIND_NMI) begin
        psw_r[`VIA_INSV_BIT] <= 1'b0;
      end else if (kind_r == via_pkg::VIA_KIND_MASK) begin
        // Level latched at decision; a priority write while stacking cannot alter it
        psw_r[`VIA_INSV_BIT] <= sel_pr_r;
      end
    end else if (wr && lnk.reg_addr == `VIA_ADDR_PSW) begin
      psw_r <= merge(psw_r, lnk.reg_wdata, lnk.reg_bitmask);
    end
  end
  assign lnk.status_word = psw_r;

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lnk.reg_rdata <= 8'h00;
    end else if (lnk.reg_re) begin
      case (lnk.reg_addr)
        `VIA_ADDR_RISE: lnk.reg_rdata <= {5'h00, rise_en_r};
        `VIA_ADDR_FALL: lnk.reg_rdata <= {5'h00, fall_en_r};
        `VIA_ADDR_PRM:  lnk.reg_rdata <= prm_r;
        `VIA_ADDR_PSW:  lnk.reg_rdata <= psw_r;
        `VIA_ADDR_REQ0: lnk.reg_rdata <= req_r[7:0];
        `VIA_ADDR_REQ1: lnk.reg_rdata <= req_r[15:8];
        `VIA_ADDR_REQ2: lnk.reg_rdata <= {5'h00, req_r[NSRC-1:16]};
        `VIA_ADDR_MSK0: lnk.reg_rdata <= msk_r[7:0];
        `VIA_ADDR_MSK1: lnk.reg_rdata <= msk_r[15:8];
        `VIA_ADDR_MSK2: lnk.reg_rdata <= {5'h1F, msk_r[NSRC-1:16]};
        `VIA_ADDR_PRI0: lnk.reg_rdata <= pri_r[7:0];
        `VIA_ADDR_PRI1: lnk.reg_rdata <= pri_r[15:8];
        `VIA_ADDR_PRI2: lnk.reg_rdata <= {5'h1F, pri_r[NSRC-1:16]};
        default:        lnk.reg_rdata <= 8'h00;
      endcase
    end else begin
      lnk.reg_rdata <= 8'h00;
    end
  end
endmodule : via_dev
`default_nettype wire

// ### include/via_defs.svh
`ifndef VIA_DEFS_SVH
`define VIA_DEFS_SVH
// Register addresses on the special register port
`define VIA_ADDR_RISE  16'hFF48
`define VIA_ADDR_FALL  16'hFF49
`define VIA_ADDR_PRM   16'hFF70
`define VIA_ADDR_PSW   16'hFF1E
`define VIA_ADDR_REQ0  16'hFFE0
`define VIA_ADDR_REQ1  16'hFFE1
`define VIA_ADDR_REQ2  16'hFFE2
`define VIA_ADDR_MSK0  16'hFFE4
`define VIA_ADDR_MSK1  16'hFFE5
`define VIA_ADDR_MSK2  16'hFFE6
`define VIA_ADDR_PRI0  16'hFFE8
`define VIA_ADDR_PRI1  16'hFFE9
`define VIA_ADDR_PRI2  16'hFFEA
// Reset values
`define VIA_RST_EDGE   8'h00
`define VIA_RST_PRM    8'h00
`define VIA_RST_PSW    8'h02
`define VIA_RST_MSKPRI 19'h7FFFF
// Field positions
`define VIA_IEN_BIT    7
`define VIA_INSV_BIT   1
`define VIA_EDGE_BITS  3
`define VIA_UPPER_ONES 8'hF8
// Source numbering, equal to fixed default priority
`define VIA_NSRC       19
`define VIA_SRC_WDT    0
`define VIA_SRC_CAP0   3
`define VIA_SRC_PIN0   6
// Vectors
`define VIA_VEC_BASE   16'h0004
`define VIA_VEC_NMI    16'h0004
`define VIA_VEC_TRAP   16'h003E
`endif

// ### include/via_pkg.sv
`default_nettype none
package via_pkg;
  // Kind of acknowledged interrupt
  typedef enum logic [1:0] {
    VIA_KIND_NMI  = 2'h0,
    VIA_KIND_MASK = 2'h1,
    VIA_KIND_SOFT = 2'h2
  } via_kind_type;
  // Acknowledge state of the device end
  typedef enum logic [2:0] {
    VIA_A_IDLE = 3'h1,
    VIA_A_DLY  = 3'h2,
    VIA_A_WAIT = 3'h4
  } via_ack_type;
  // Stacking state of the sequencer end
  typedef enum logic [4:0] {
    VIA_S_IDLE = 5'h01,
    VIA_S_PSW  = 5'h02,
    VIA_S_PCH  = 5'h04,
    VIA_S_PCL  = 5'h08,
    VIA_S_JMP  = 5'h10
  } via_seq_type;
endpackage : via_pkg
`default_nettype wire

// ### include/via_link_if.sv
`default_nettype none
interface via_link_if;
  logic                    bnd;       // Instruction boundary pulse
  logic                    hold;      // Boundary follows a hold instruction or a return
  logic                    trap;      // Boundary ends a trap instruction
  logic                    interrupt_return_instr;      // Interrupt return executed
  logic                    break_return_instr;      // Break return executed
  logic [15:0]             reg_addr;
  logic [7:0]              reg_wdata;
  logic [7:0]              reg_bitmask;
  logic                    reg_we;
  logic                    reg_re;
  logic [7:0]              reg_rdata;
  logic                    ack;       // Acknowledge pulse
  via_pkg::via_kind_type   ack_kind;
  logic [15:0]             ack_vec;
  logic [7:0]              status_word;       // Live status word
  logic                    ack_done;  // Stacking finished
  modport dev (input bnd, hold, trap, interrupt_return_instr, break_return_instr, reg_addr, reg_wdata, reg_bitmask,
               input reg_we, reg_re, ack_done,
               output reg_rdata, ack, ack_kind, ack_vec, status_word);
  modport seq (output bnd, hold, trap, interrupt_return_instr, break_return_instr, reg_addr, reg_wdata, reg_bitmask,
               output reg_we, reg_re, ack_done,
               input reg_rdata, ack, ack_kind, ack_vec, status_word);
endinterface : via_link_if
`default_nettype wire

// ### logic/via_seq.sv
`include "via_defs.svh"
`default_nettype none
module via_seq (
  input  wire logic  i_clk_sys,
  input  wire logic  i_arst_n,
  input  wire logic  i_bnd,
  input  wire logic  i_hold,
  input  wire logic  i_trap,
  input  wire logic  i_interrupt_return_instr,
  input  wire logic  i_break_return_instr,
  input  wire logic  i_timer_run,
  input  wire logic  i_wdt_wd_mode,
  input  wire logic [15:0] i_pc,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic [7:0]  i_bitmask,
  input  wire logic  i_we,
  input  wire logic  i_re,
  output logic [7:0] o_rdata,
  output logic       o_busy,
  output logic       o_push_valid,
  output logic [7:0] o_push_data,
  output logic       o_branch,
  output logic [15:0] o_branch_pc,
  via_link_if.seq    lnk
);
  via_pkg::via_seq_type st_r;
  logic [15:0]          pc_r;
  logic                 wr_ok;
  logic [7:0]           wd;

  // Boundaries pass only while no stacking runs
  assign lnk.bnd  = i_bnd & (st_r == via_pkg::VIA_S_IDLE);
  assign lnk.hold = i_hold | i_interrupt_return_instr | i_break_return_instr;
  assign lnk.trap = i_trap;
  assign lnk.interrupt_return_instr = i_interrupt_return_instr;
  assign lnk.break_return_instr = i_break_return_instr;
  assign lnk.reg_addr    = i_addr;
  assign lnk.reg_bitmask = i_bitmask;
  assign lnk.reg_re      = i_re;
  assign o_rdata         = lnk.reg_rdata;
  assign o_busy          = (st_r != via_pkg::VIA_S_IDLE);
  assign lnk.ack_done    = (st_r == via_pkg::VIA_S_JMP);
  assign o_branch        = (st_r == via_pkg::VIA_S_JMP);
  assign o_branch_pc     = pc_r;

  // Capture edge selection changes only with the timer stopped
  assign wr_ok = ~(i_timer_run && i_addr == `VIA_ADDR_PRM);
  always_comb begin
    wd = i_wdata;
    if (i_addr == `VIA_ADDR_PRI2) begin
      wd = i_wdata | `VIA_UPPER_ONES;
    end
    if (i_addr == `VIA_ADDR_PRI0 && i_wdt_wd_mode) begin
      wd[`VIA_SRC_WDT] = 1'b1;
    end
  end
  assign lnk.reg_wdata = wd;
  assign lnk.reg_we    = i_we & wr_ok;

  // Stacking: status word first, then return address
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r         <= via_pkg::VIA_S_IDLE;
      pc_r         <= 16'h0000;
      o_push_valid <= 1'b0;
      o_push_data  <= 8'h00;
    end else begin
      o_push_valid <= 1'b0;
      case (st_r)
        via_pkg::VIA_S_IDLE: begin
          if (lnk.ack) begin
            pc_r <= i_pc;
            st_r <= via_pkg::VIA_S_PSW;
          end
        end
        via_pkg::VIA_S_PSW: begin
          o_push_valid <= 1'b1;
          o_push_data  <= lnk.status_word;
          st_r         <= via_pkg::VIA_S_PCH;
        end
        via_pkg::VIA_S_PCH: begin
          o_push_valid <= 1'b1;
          o_push_data  <= pc_r[15:8];
          st_r         <= via_pkg::VIA_S_PCL;
        end
        via_pkg::VIA_S_PCL: begin
          o_push_valid <= 1'b1;
          o_push_data  <= pc_r[7:0];
          pc_r         <= lnk.ack_vec;
          st_r         <= via_pkg::VIA_S_JMP;
        end
        via_pkg::VIA_S_JMP: begin
          st_r <= via_pkg::VIA_S_IDLE;
        end
        default: begin
          st_r <= via_pkg::VIA_S_IDLE;
        end
      endcase
    end
  end
endmodule : via_seq
`default_nettype wire

// ### dv/via_monitor.sv
`default_nettype none
module via_monitor (
  input wire logic                  i_clk_sys,
  input wire logic                  i_arst_n,
  input wire logic                  bnd,
  input wire logic                  hold,
  input wire logic                  trap,
  input wire logic                  ack,
  input wire via_pkg::via_kind_type ack_kind,
  input wire logic [15:0]           ack_vec,
  input wire logic [7:0]            status_word,
  input wire logic                  ack_done
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_arst_n);

  // Stacking of three bytes ends in the branch four cycles after acknowledge
  sequence stack_s;
    !ack_done [*4] ##1 ack_done;
  endsequence
  // Trap answer is soft kind on the fixed trap vector
  sequence trap_ack_s;
    ack && ack_kind == via_pkg::VIA_KIND_SOFT && ack_vec == 16'h003E;
  endsequence

  // Decisions only come from a boundary one or two cycles back
  ack_source_a: assert property (ack |-> $past(bnd) || $past(bnd, 2))
    else $error("acknowledge without a boundary");
  trap_taken_a: assert property (bnd && trap |=> trap_ack_s)
    else $error("trap not answered next cycle");
  nmi_vector_a: assert property (
    ack && ack_kind == via_pkg::VIA_KIND_NMI |-> ack_vec == 16'h0004)
    else $error("non-maskable vector wrong");
  mask_vector_a: assert property (
    ack && ack_kind == via_pkg::VIA_KIND_MASK |->
      !ack_vec[0] && ack_vec >= 16'h0004 && ack_vec <= 16'h0028)
    else $error("maskable vector outside table");
  // Hold boundaries defer everything except the trap
  hold_refuse_a: assert property (bnd && hold && !trap |=> !ack [*2])
    else $error("acknowledge at a hold boundary");
  stack_order_a: assert property (ack |-> stack_s)
    else $error("branch not four cycles after acknowledge");
  enable_clear_a: assert property (ack_done |=> !status_word[7])
    else $error("enable flag not cleared");
  nmi_flags_a: assert property (
    ack_done && ack_kind == via_pkg::VIA_KIND_NMI |=> !status_word[1])
    else $error("in-service flag not cleared");
endmodule : via_monitor
`default_nettype wire

// ### dv/tb_vectored_interrupt_acknowledge.sv
`include "via_defs.svh"
`default_nettype none
module tb_vectored_interrupt_acknowledge;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys, arst_n, bnd, hold, trap, interrupt_return_instr, timer_run, wd_mode, ovf, we, re;
  logic        busy, pushv, nmi_busy, branch;
  logic [15:0] pc, addr, branch_pc, exp;
  logic [7:0]  wdata, bmask, rdata, pushd;
  logic [18:0] src;
  logic [2:0]  ext_pin, cap_pin;
  logic [1:0]  e;
  logic [31:0] seed;
  logic [7:0]  pushq[$];
  int          fails, num_checks, p;

  via_link_if lnk ();
  via_seq via_seq_inst (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_bnd(bnd), .i_hold(hold),
    .i_trap(trap), .i_interrupt_return_instr(interrupt_return_instr), .i_break_return_instr(1'b0), .i_timer_run(timer_run),
    .i_wdt_wd_mode(wd_mode), .i_pc(pc), .i_addr(addr), .i_wdata(wdata), .i_bitmask(bmask),
    .i_we(we), .i_re(re), .o_rdata(rdata), .o_busy(busy), .o_push_valid(pushv),
    .o_push_data(pushd), .o_branch(branch), .o_branch_pc(branch_pc), .lnk(lnk));
  via_dev #(.NSRC(`VIA_NSRC)) via_dev_inst (.i_clk_sys(clk_sys), .i_arst_n(arst_n),
    .i_src_pulse(src), .i_ext_pin(ext_pin), .i_capture_pin(cap_pin), .i_wdt_overflow(ovf),
    .i_wdt_nmi_mode(1'b1), .o_nmi_busy(nmi_busy), .lnk(lnk));
  via_monitor via_monitor_inst (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .bnd(lnk.bnd),
    .hold(lnk.hold), .trap(lnk.trap), .ack(lnk.ack), .ack_kind(lnk.ack_kind),
    .ack_vec(lnk.ack_vec), .status_word(lnk.status_word), .ack_done(lnk.ack_done));

  // Clock at 250 MHz
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Collect stacked bytes in push order
  always @(posedge clk_sys) begin
    if (pushv === 1'b1) pushq.push_back(pushd);
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Request bits a single pin edge should raise; capture code 2 detects nothing
  function automatic logic [15:0] edge_req(input int q, input logic [1:0] c, input logic up);
    logic pin_hit, cap_hit;
    pin_hit = up ? c[1] : c[0];
    cap_hit = up ? c[0] : (c != 2'h1 && c != 2'h2);
    return (16'(pin_hit) << (6 + q)) | (16'(cap_hit) << (3 + q));
  endfunction : edge_req

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    bmask <= m;
    we    <= 1'b1;
    @(posedge clk_sys);
    we <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rc(input logic [15:0] a, input logic [7:0] want);
    @(posedge clk_sys);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk_sys);
    re <= 1'b0;
    #1 chk(16'(rdata), 16'(want));
  endtask : rc
  task automatic pulse(input logic [18:0] s, input logic o);
    @(posedge clk_sys);
    src <= s;
    ovf <= o;
    @(posedge clk_sys);
    src <= 19'h0;
    ovf <= 1'b0;
  endtask : pulse
  // One boundary; twelve cycles cover acknowledge, stacking and branch
  task automatic bd(input logic h, input logic r, input logic t, input logic a,
                    input logic [15:0] v, input logic [1:0] lat, input logic [7:0] pw);
    int n;
    int brs;
    logic got;
    logic [1:0] when;
    brs  = 0;
    got  = 1'b0;
    when = 2'h0;
    pushq.delete();
    @(posedge clk_sys);
    bnd  <= 1'b1;
    hold <= h;
    interrupt_return_instr <= r;
    trap <= t;
    pc   <= seed[15:0];
    @(posedge clk_sys);
    bnd  <= 1'b0;
    hold <= 1'b0;
    interrupt_return_instr <= 1'b0;
    trap <= 1'b0;
    for (n = 0; n < 12; n++) begin
      #1;
      if (branch === 1'b1) brs++;
      if (lnk.ack === 1'b1 && !got) begin
        got  = 1'b1;
        when = n[1:0];
      end
      @(posedge clk_sys);
    end
    chk(16'(got), 16'(a));
    chk(16'(brs), 16'(a));
    if (a) begin
      chk(lnk.ack_vec, v);
      chk(branch_pc, v);
      chk(16'(when), 16'(lat));
      chk(16'(pushq.size()), 16'h0003);
      chk({8'h00, pushq[0]}, {8'h00, pw});
      chk({pushq[1], pushq[2]}, pc);
    end
    chk(16'(busy), 16'h0000);
    seed = lfsr(seed);
  endtask : bd

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  // Hang guard
  initial begin
    repeat (50000) @(posedge clk_sys);
    fails++;
    conclude();
  end

  initial begin
    {bnd, hold, trap, interrupt_return_instr, timer_run, wd_mode, ovf, we, re} = 9'h000;
    {pc, addr, wdata, bmask} = 48'h0;
    {src, ext_pin, cap_pin} = 25'h0;
    {fails, num_checks} = 64'h0;
    seed = 32'h7EC3D876;
    arst_n = 1'b0;
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rc(`VIA_ADDR_RISE, `VIA_RST_EDGE);
    rc(`VIA_ADDR_FALL, `VIA_RST_EDGE);
    rc(`VIA_ADDR_PRM, `VIA_RST_PRM);
    rc(`VIA_ADDR_PSW, `VIA_RST_PSW);
    rc(`VIA_ADDR_REQ0, 8'h00);
    $display("test reset done");
    wr(`VIA_ADDR_RISE, 8'hFF, 8'hFF);
    rc(`VIA_ADDR_RISE, 8'h07);
    wr(`VIA_ADDR_FALL, 8'hFF, 8'h02);
    rc(`VIA_ADDR_FALL, 8'h02);
    wr(`VIA_ADDR_PRM, 8'hA5, 8'h0F);
    rc(`VIA_ADDR_PRM, 8'h00);
    timer_run <= 1'b1;
    wr(`VIA_ADDR_PRM, seed[7:0], 8'hFF);
    rc(`VIA_ADDR_PRM, 8'h00);
    timer_run <= 1'b0;
    wr(`VIA_ADDR_PRM, seed[15:8], 8'hFF);
    rc(`VIA_ADDR_PRM, seed[15:8]);
    wr(`VIA_ADDR_PRI2, 8'h00, 8'hFF);
    rc(`VIA_ADDR_PRI2, 8'hF8);
    wd_mode <= 1'b1;
    wr(`VIA_ADDR_PRI0, 8'h00, 8'hFF);
    rc(`VIA_ADDR_PRI0, 8'h01);
    wd_mode <= 1'b0;
    wr(`VIA_ADDR_PRI0, 8'hFF, 8'hFF);
    wr(`VIA_ADDR_PSW, 8'h41, 8'hFF);
    wr(`VIA_ADDR_PSW, 8'h00, 8'h01);
    rc(`VIA_ADDR_PSW, 8'h40);
    rc(16'hFF00, 8'h00);
    $display("test registers done");
    // Every edge code on a randomly chosen pin and capture input
    for (int c = 0; c < 4; c++) begin
      p = seed % 3;
      e = c[1:0];
      wr(`VIA_ADDR_RISE, {7'h00, e[1]} << p, 8'hFF);
      wr(`VIA_ADDR_FALL, {7'h00, e[0]} << p, 8'hFF);
      wr(`VIA_ADDR_PRM, {6'h00, e} << (2 + 2 * p), 8'hFF);
      for (int up = 1; up >= 0; up--) begin
        wr(`VIA_ADDR_REQ0, 8'h00, 8'hFF);
        wr(`VIA_ADDR_REQ1, 8'h00, 8'hFF);
        ext_pin <= up[0] ? 3'h1 << p : 3'h0;
        cap_pin <= up[0] ? 3'h1 << p : 3'h0;
        repeat (6) @(posedge clk_sys);
        exp = edge_req(p, e, up[0]);
        rc(`VIA_ADDR_REQ0, exp[7:0]);
        rc(`VIA_ADDR_REQ1, exp[15:8]);
      end
      seed = lfsr(seed);
    end
    wr(`VIA_ADDR_PRM, 8'h00, 8'hFF);
    wr(`VIA_ADDR_REQ0, 8'h00, 8'hFF);
    // Last falling edge may have left the third pin's flag set
    wr(`VIA_ADDR_REQ1, 8'h00, 8'hFF);
    $display("test edges done");
    wr(`VIA_ADDR_PSW, 8'h82, 8'hFF);
    bd(1'b1, 1'b0, 1'b1, 1'b1, `VIA_VEC_TRAP, 2'h0, 8'h82);
    rc(`VIA_ADDR_PSW, 8'h02);
    $display("test trap done");
    // Enable flag is low here, so the take proves it is not maskable
    pulse(19'h0, 1'b1);
    bd(1'b0, 1'b0, 1'b0, 1'b1, `VIA_VEC_NMI, 2'h0, 8'h02);
    rc(`VIA_ADDR_PSW, 8'h00);
    chk(16'(nmi_busy), 16'h0001);
    pulse(19'h0, 1'b1);
    pulse(19'h0, 1'b1);
    bd(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 2'h0, 8'h00);
    bd(1'b0, 1'b1, 1'b0, 1'b0, 16'h0000, 2'h0, 8'h00);
    wr(`VIA_ADDR_PSW, 8'h02, 8'hFF);
    bd(1'b0, 1'b0, 1'b0, 1'b1, `VIA_VEC_NMI, 2'h0, 8'h02);
    bd(1'b0, 1'b1, 1'b0, 1'b0, 16'h0000, 2'h0, 8'h00);
    bd(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 2'h0, 8'h00);
    $display("test nmi done");
    // Sources 1 and 2 low level, source 10 high level, all at once
    wr(`VIA_ADDR_MSK0, 8'hF9, 8'hFF);
    wr(`VIA_ADDR_MSK1, 8'hFB, 8'hFF);
    wr(`VIA_ADDR_PRI1, 8'hFB, 8'hFF);
    wr(`VIA_ADDR_PSW, 8'h82, 8'hFF);
    pulse(19'h00406, 1'b0);
    rc(`VIA_ADDR_REQ0, 8'h06);
    rc(`VIA_ADDR_REQ1, 8'h04);
    bd(1'b1, 1'b0, 1'b0, 1'b0, 16'h0000, 2'h0, 8'h00);
    bd(1'b0, 1'b0, 1'b0, 1'b1, 16'h0018, 2'h0, 8'h82);
    rc(`VIA_ADDR_PSW, 8'h00);
    rc(`VIA_ADDR_REQ1, 8'h00);
    bd(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 2'h0, 8'h00);
    wr(`VIA_ADDR_PSW, 8'h80, 8'hFF);
    bd(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 2'h0, 8'h00);
    wr(`VIA_ADDR_PSW, 8'h82, 8'hFF);
    bd(1'b0, 1'b0, 1'b0, 1'b1, 16'h0006, 2'h1, 8'h82);
    rc(`VIA_ADDR_PSW, 8'h02);
    rc(`VIA_ADDR_REQ0, 8'h04);
    wr(`VIA_ADDR_PSW, 8'h82, 8'hFF);
    bd(1'b0, 1'b0, 1'b0, 1'b1, 16'h0008, 2'h1, 8'h82);
    $display("test maskable done");
    conclude();
  end
endmodule : tb_vectored_interrupt_acknowledge
`default_nettype wire
